// >>> design/seap_serial.sv
// Purpose: Bit-serial engine for a 16-bit organised serial memory.
// Assumes: din is already synchronised to aclk.
// Notes: Serial clock is divided from aclk, so no second clock domain.
module seap_serial (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic start,
  input wire logic [26:0] tx_word,
  input wire logic [4:0] tx_len,
  input wire logic [4:0] rx_len,
  input wire logic wait_ready,
  input wire logic din,
  output logic done,
  output logic [15:0] rx_word,
  output logic cs,
  output logic sk,
  output logic dout
);
  typedef enum logic [1:0] {SEAP_IDLE, SEAP_SHIFT, SEAP_GAP, SEAP_POLL} seap_ser_state_t;
  seap_ser_state_t state;
  logic [26:0] shreg;
  logic [4:0] bitcnt;
  logic [4:0] total;
  logic [4:0] txl;
  logic [3:0] timer;
  logic poll;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= SEAP_IDLE;
      shreg <= 27'h000_0000;
      bitcnt <= 5'h0_0;
      total <= 5'h0_0;
      txl <= 5'h0_0;
      timer <= 4'h0;
      poll <= 1'b0;
      done <= 1'b0;
      rx_word <= 16'h0000;
      cs <= 1'b0;
      sk <= 1'b0;
      dout <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state)
        SEAP_IDLE: begin
          if (start) begin
            shreg <= {tx_word[25:0], 1'b0};
            dout <= tx_word[26]; // [RULE16]
            total <= 5'(tx_len + rx_len);
            txl <= tx_len;
            poll <= wait_ready;
            bitcnt <= 5'h0_0;
            cs <= 1'b1; // [RULE2]
            timer <= 4'(seap_pkg::SK_HALF_CYC);
            state <= SEAP_SHIFT;
          end
        end
        SEAP_SHIFT: begin
          if (timer > 4'h1) begin
            timer <= timer - 4'h1;
          end else begin
            timer <= 4'(seap_pkg::SK_HALF_CYC);
            sk <= ~sk;
            if (sk) begin
              // Sampled late in the high phase so the synchroniser lag is absorbed
              if (bitcnt >= txl) begin
                rx_word <= {rx_word[14:0], din};
              end
              dout <= shreg[26];
              shreg <= {shreg[25:0], 1'b0};
              bitcnt <= bitcnt + 5'h0_1;
              if (bitcnt == 5'(total - 5'h0_1)) begin
                cs <= 1'b0;
                dout <= 1'b0;
                timer <= 4'(seap_pkg::CS_GAP_CYC);
                state <= SEAP_GAP;
              end
            end
          end
        end
        SEAP_GAP: begin
          if (timer > 4'h1) begin
            timer <= timer - 4'h1;
          end else if (poll) begin
            cs <= 1'b1;
            timer <= 4'(seap_pkg::SK_HALF_CYC);
            state <= SEAP_POLL;
          end else begin
            done <= 1'b1;
            state <= SEAP_IDLE;
          end
        end
        SEAP_POLL: begin
          if (timer > 4'h1) begin
            timer <= timer - 4'h1;
          end else if (din) begin // [RULE17]
            cs <= 1'b0;
            done <= 1'b1;
            state <= SEAP_IDLE;
          end
        end
        default: state <= SEAP_IDLE;
      endcase
    end
  end
endmodule : seap_serial

// >>> design/seap_sync.sv
// Purpose: Two-stage synchroniser for pin inputs.
// Assumes: Inputs are asynchronous to aclk.
// Notes: First stage is read only by the second.
module seap_sync #(
  parameter int WIDTH = 1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        stage1[i] <= 1'b0;
        sync_out[i] <= 1'b0;
      end else begin
        stage1[i] <= async_in[i];
        sync_out[i] <= stage1[i];
      end
    end
  end
endmodule : seap_sync

// >>> design/seap_top.sv
// Purpose: Serial EEPROM access port behind an AXI4-Lite register slave.
// Assumes: Memory link pins are programmed non-inverting by software.
// Notes: Lock bits clear only on aresetn, which acts as the hard reset.
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
module seap_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [seap_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [seap_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic eeprom_serial_in_pin,
  output logic eeprom_serial_out_pin,
  output logic eeprom_serial_clock_pin,
  output logic eeprom_chip_enable_pin,
  output logic irq
);
  typedef enum logic [1:0] {SEAP_E_IDLE, SEAP_E_EWEN, SEAP_E_WRITE, SEAP_E_READ} seap_eng_t;

  // Write channel holding
  logic aw_held;
  logic w_held;
  logic [seap_pkg::ADDR_W-1:0] aw_addr;
  logic [7:0] w_byte;
  logic w_lane0;
  logic next_aw_held;
  logic next_w_held;
  logic next_bvalid;
  logic next_rvalid;
  logic do_write;
  logic do_read;
  logic wr_fire;
  logic [9:0] wr_idx;
  logic [9:0] rd_idx;

  // Register state
  logic cfg_mode;
  logic [3:0] lock;
  logic type_large;
  logic [7:0] pointer;
  logic write_mode;
  logic [1:0] wstat;
  logic [15:0] wr_word;
  logic [15:0] rd_word;
  logic rd_valid;
  logic rd_high;
  logic [seap_pkg::IRQ_W-1:0] irq_status;
  logic [seap_pkg::IRQ_W-1:0] irq_mask;
  logic [seap_pkg::IRQ_W-1:0] irq_event;

  // Engine
  seap_eng_t eng;
  logic pend_write;
  logic pend_read;
  logic ser_start;
  logic [26:0] ser_tx;
  logic [4:0] ser_txlen;
  logic [4:0] ser_rxlen;
  logic ser_wait;
  logic ser_done;
  logic [15:0] ser_rx;
  logic din_sync;
  logic locked;
  logic [7:0] addr_field;
  logic [4:0] hdr_len;

  // Byte-level side effects of host accesses
  logic wb_low;
  logic wb_high;
  logic ptr_write;
  logic rb_high;
  logic rd_access;
  logic [31:0] rd_value;
  logic rd_mapped;

  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign do_read = s_axi_arvalid && s_axi_arready;
  assign wr_fire = do_write && w_lane0;
  assign wr_idx = aw_addr[seap_pkg::ADDR_W-1:2];
  assign rd_idx = s_axi_araddr[seap_pkg::ADDR_W-1:2];
  assign next_aw_held = do_write ? 1'b0 : (aw_held || (s_axi_awvalid && s_axi_awready));
  assign next_w_held = do_write ? 1'b0 : (w_held || (s_axi_wvalid && s_axi_wready));
  assign next_bvalid = do_write || (s_axi_bvalid && !s_axi_bready);
  assign next_rvalid = do_read || (s_axi_rvalid && !s_axi_rready);

  // Memory registers answer only in configuration mode
  assign rd_access = do_read && cfg_mode; // [RULE4]
  assign wb_low = wr_fire && cfg_mode && wr_idx == seap_pkg::IDX_WRITE_BYTE
                  && wstat == seap_pkg::WSTAT_READY; // [RULE8]
  assign wb_high = wr_fire && cfg_mode && wr_idx == seap_pkg::IDX_WRITE_BYTE
                   && wstat == seap_pkg::WSTAT_LOW_HELD; // [RULE8]
  assign ptr_write = wr_fire && cfg_mode && wr_idx == seap_pkg::IDX_POINTER; // [RULE7]
  assign rb_high = rd_access && rd_idx == seap_pkg::IDX_READ_BYTE
                   && rd_valid && rd_high; // [RULE15]

  // Lower 64 words fall in four 16-word (32-byte) blocks
  assign locked = (pointer < 8'(seap_pkg::LOCKED_WORDS)) && lock[pointer[5:4]]; // [RULE5]

  // AXI4-Lite handshakes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 12'h000;
      w_byte <= 8'h00;
      w_lane0 <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= seap_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_byte <= s_axi_wdata[7:0];
        w_lane0 <= s_axi_wstrb[0];
      end
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      s_axi_bvalid <= next_bvalid;
      // One write in flight; ready drops while held or answering
      s_axi_awready <= !next_aw_held && !next_bvalid;
      s_axi_wready <= !next_w_held && !next_bvalid;
      if (do_write) begin
        s_axi_bresp <= (wr_idx >= seap_pkg::IDX_MODE && wr_idx <= seap_pkg::IDX_READ_HS)
                       || (wr_idx >= seap_pkg::IDX_CONTROL && wr_idx <= seap_pkg::IDX_IRQ_MASK)
                       ? seap_pkg::RESP_OKAY : seap_pkg::RESP_SLVERR;
      end
    end
  end

  // Read data mux
  always_comb begin
    rd_value = 32'h0000_0000;
    rd_mapped = 1'b1;
    case (rd_idx)
      seap_pkg::IDX_MODE: rd_value = {27'h000_0000, type_large, lock};
      seap_pkg::IDX_POINTER: rd_value = {24'h00_0000, pointer}; // [RULE7]
      seap_pkg::IDX_WRITE_BYTE: rd_value = 32'h0000_0000;
      seap_pkg::IDX_WRITE_HS: rd_value = {24'h00_0000, write_mode, 5'h0_0, wstat}; // [RULE10]
      seap_pkg::IDX_READ_BYTE: rd_value = {24'h00_0000, rd_high ? rd_word[15:8] : rd_word[7:0]}; // [RULE13]
      seap_pkg::IDX_READ_HS: rd_value = {31'h0000_0000, rd_valid};
      seap_pkg::IDX_CONTROL: rd_value = {31'h0000_0000, cfg_mode};
      seap_pkg::IDX_IRQ_STATUS: rd_value = {29'h0000_0000, irq_status};
      seap_pkg::IDX_IRQ_MASK: rd_value = {29'h0000_0000, irq_mask};
      default: rd_mapped = 1'b0;
    endcase
    // Memory registers read as zero outside configuration mode
    if (!cfg_mode && rd_idx >= seap_pkg::IDX_MODE && rd_idx <= seap_pkg::IDX_READ_HS) begin
      rd_value = 32'h0000_0000; // [RULE4]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= seap_pkg::RESP_OKAY;
    end else begin
      s_axi_rvalid <= next_rvalid;
      s_axi_arready <= !next_rvalid && !do_read;
      if (do_read) begin
        s_axi_rdata <= rd_value;
        s_axi_rresp <= rd_mapped ? seap_pkg::RESP_OKAY : seap_pkg::RESP_SLVERR;
      end
    end
  end

  // Configuration mode, type select and locks
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_mode <= 1'b0;
      lock <= 4'h0;
      type_large <= 1'b0;
      irq_mask <= 3'h0;
    end else if (wr_fire) begin
      if (wr_idx == seap_pkg::IDX_CONTROL) begin
        cfg_mode <= w_byte[seap_pkg::CTRL_CFG_BIT];
      end
      if (wr_idx == seap_pkg::IDX_IRQ_MASK) begin
        irq_mask <= w_byte[seap_pkg::IRQ_W-1:0];
      end
      if (cfg_mode && wr_idx == seap_pkg::IDX_MODE) begin
        lock <= lock | w_byte[3:0]; // [RULE6]
        type_large <= w_byte[seap_pkg::MODE_TYPE_BIT]; // [RULE3]
      end
    end
  end

  // Direction select
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      write_mode <= 1'b0;
    end else if (wr_fire && cfg_mode && wr_idx == seap_pkg::IDX_WRITE_HS) begin
      write_mode <= w_byte[seap_pkg::WHS_DIR_BIT]; // [RULE12]
    end
  end

  // Write byte pairing and write status
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wstat <= seap_pkg::WSTAT_READY;
      wr_word <= 16'h0000;
    end else begin
      if (wb_low) begin
        wr_word[7:0] <= w_byte;
        wstat <= seap_pkg::WSTAT_LOW_HELD; // [RULE9]
      end else if (wb_high) begin
        wr_word[15:8] <= w_byte;
        wstat <= seap_pkg::WSTAT_BUSY; // [RULE9]
      end else if (eng == SEAP_E_WRITE && ser_done) begin
        wstat <= seap_pkg::WSTAT_READY; // [RULE17]
      end else if (eng == SEAP_E_IDLE && pend_write && locked) begin
        wstat <= seap_pkg::WSTAT_READY; // [RULE5]
      end
    end
  end

  // Pointer, read pairing and valid flag
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pointer <= 8'h00;
      rd_high <= 1'b0;
      rd_valid <= 1'b0;
      rd_word <= 16'h0000;
    end else begin
      if (ptr_write) begin
        pointer <= w_byte; // [RULE7]
        rd_valid <= 1'b0;
        rd_high <= 1'b0;
      end else if (rb_high) begin
        rd_valid <= 1'b0; // [RULE14]
        rd_high <= 1'b0;
        pointer <= pointer + 8'h01; // [RULE14]
      end else if (rd_access && rd_idx == seap_pkg::IDX_READ_BYTE && rd_valid) begin
        rd_high <= 1'b1; // [RULE13]
      end else if (eng == SEAP_E_WRITE && ser_done) begin
        pointer <= pointer + 8'h01; // [RULE7]
      end else if (eng == SEAP_E_IDLE && pend_write && locked) begin
        pointer <= pointer + 8'h01;
      end else if (eng == SEAP_E_READ && ser_done && !pend_read) begin
        rd_word <= ser_rx;
        rd_valid <= 1'b1; // [RULE14]
      end else if (eng == SEAP_E_IDLE && !pend_write && pend_read && locked) begin
        // Denied words read back as zero but still complete the handshake
        rd_word <= 16'h0000;
        rd_valid <= 1'b1;
      end
    end
  end

  // Pending jobs; a pointer change during a fetch reruns it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pend_write <= 1'b0;
      pend_read <= 1'b0;
    end else begin
      if (wb_high) begin
        pend_write <= 1'b1;
      end else if (eng == SEAP_E_IDLE && pend_write) begin
        pend_write <= 1'b0;
      end
      if ((ptr_write || rb_high) && !write_mode) begin
        pend_read <= 1'b1; // [RULE12]
      end else if (((eng == SEAP_E_WRITE && ser_done) || (eng == SEAP_E_IDLE && pend_write
                   && locked)) && !write_mode) begin
        pend_read <= 1'b1; // [RULE12]
      end else if (eng == SEAP_E_IDLE && !pend_write && pend_read) begin
        pend_read <= 1'b0;
      end
    end
  end

  // Short address for small types, long for large
  assign addr_field = type_large ? pointer : {pointer[5:0], 2'b00}; // [RULE3]
  assign hdr_len = type_large ? 5'd11 : 5'd9; // [RULE16]

  // Serial job sequencing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      eng <= SEAP_E_IDLE;
      ser_start <= 1'b0;
      ser_tx <= 27'h000_0000;
      ser_txlen <= 5'h0_0;
      ser_rxlen <= 5'h0_0;
      ser_wait <= 1'b0;
    end else begin
      ser_start <= 1'b0;
      case (eng)
        SEAP_E_IDLE: begin
          if (pend_write && !locked) begin
            // Memory powers up write-protected, so each write is preceded by enable
            ser_tx <= {seap_pkg::OP_EWEN, seap_pkg::EWEN_FIELD, 22'h00_0000}; // [RULE16]
            ser_txlen <= hdr_len;
            ser_rxlen <= 5'h0_0;
            ser_wait <= 1'b0;
            ser_start <= 1'b1;
            eng <= SEAP_E_EWEN;
          end else if (!pend_write && pend_read && !locked) begin
            ser_tx <= {seap_pkg::OP_READ, addr_field, 16'h0000}; // [RULE16]
            ser_txlen <= hdr_len;
            ser_rxlen <= 5'h1_0;
            ser_wait <= 1'b0;
            ser_start <= 1'b1;
            eng <= SEAP_E_READ;
          end
        end
        SEAP_E_EWEN: begin
          if (ser_done) begin
            ser_tx <= type_large ? {seap_pkg::OP_WRITE, pointer, wr_word}
                      : {seap_pkg::OP_WRITE, pointer[5:0], wr_word, 2'b00}; // [RULE9]
            ser_txlen <= 5'(hdr_len + 5'h1_0);
            ser_rxlen <= 5'h0_0;
            ser_wait <= 1'b1; // [RULE17]
            ser_start <= 1'b1;
            eng <= SEAP_E_WRITE;
          end
        end
        SEAP_E_WRITE: begin
          if (ser_done) begin
            eng <= SEAP_E_IDLE;
          end
        end
        SEAP_E_READ: begin
          if (ser_done) begin
            eng <= SEAP_E_IDLE;
          end
        end
        default: eng <= SEAP_E_IDLE;
      endcase
    end
  end

  // Interrupt events; a read clears status but a same-cycle event survives
  always_comb begin
    irq_event = '0;
    irq_event[seap_pkg::IRQ_WRITE_DONE] = eng == SEAP_E_WRITE && ser_done;
    irq_event[seap_pkg::IRQ_READ_VALID] = (eng == SEAP_E_READ && ser_done && !pend_read)
        || (eng == SEAP_E_IDLE && !pend_write && pend_read && locked);
    irq_event[seap_pkg::IRQ_LOCK_DENY] = eng == SEAP_E_IDLE && locked
        && (pend_write || pend_read);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status <= 3'h0;
      irq <= 1'b0;
    end else begin
      if (do_read && rd_idx == seap_pkg::IDX_IRQ_STATUS) begin
        irq_status <= irq_event;
      end else begin
        irq_status <= irq_status | irq_event;
      end
      irq <= |(irq_status & irq_mask);
    end
  end

  seap_sync #(
    .WIDTH(1)
  ) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in(eeprom_serial_in_pin),
    .sync_out(din_sync)
  );

  seap_serial u_serial (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(ser_start),
    .tx_word(ser_tx),
    .tx_len(ser_txlen),
    .rx_len(ser_rxlen),
    .wait_ready(ser_wait),
    .din(din_sync),
    .done(ser_done),
    .rx_word(ser_rx),
    .cs(eeprom_chip_enable_pin),
    .sk(eeprom_serial_clock_pin),
    .dout(eeprom_serial_out_pin)
  );
endmodule : seap_top

// >>> inc/seap_pkg.sv
// Purpose: Constants for the serial EEPROM access port.
// Assumes: 10 MHz aclk, AXI4-Lite register access, 32-bit data.
// Notes: Printed offsets are indices; byte address is four times the index.
// Operation
// [RULE1] Software sets the four link pins to non-inverting before any use of the link.
// [RULE2] The memory is driven over a data-in, a data-out, a clock and a chip-enable pin.
// [RULE3] Mode bit 4 picks the small memory types when clear and the large ones when set.
// [RULE4] The memory registers are reachable only while configuration mode is on.
// [RULE5] Mode bits 0 to 3 each deny access to one 32-byte block of the first 128 bytes.
// [RULE6] A set lock bit cannot be cleared by software, only by hard or power-on reset.
// [RULE7] The pointer is writable, reads back the word address, and steps after each pair.
// [RULE8] A word is written as two byte writes, low byte first, and assembled into one word.
// [RULE9] The first byte write clears write-status bit 0, the second clears bit 1 and writes.
// [RULE10] Write status 11 is ready, 10 awaits the high byte, 00 means a write is in progress.
// [RULE11] Software polls the write status for ready before each pair of byte writes.
// [RULE12] Write-status bit 7 clear selects read mode with prefetch on every pointer update.
// [RULE13] Read data gives the low byte then the high byte, valid only while read-status bit 0.
// [RULE14] Reading the high byte clears valid, steps the pointer, fetches, then sets valid.
// [RULE15] Reading data while not valid has no side effect besides returning invalid data.
// [RULE16] The serial opcode, address and data sequence uses a short or long address by type.
// [RULE17] Programming completion is seen as ready on serial data-in and restores status 11.
package seap_pkg;
  localparam int ADDR_W = 12;
  localparam logic [9:0] IDX_MODE = 10'h0f1;
  localparam logic [9:0] IDX_POINTER = 10'h0f2;
  localparam logic [9:0] IDX_WRITE_BYTE = 10'h0f3;
  localparam logic [9:0] IDX_WRITE_HS = 10'h0f4;
  localparam logic [9:0] IDX_READ_BYTE = 10'h0f5;
  localparam logic [9:0] IDX_READ_HS = 10'h0f6;
  localparam logic [9:0] IDX_CONTROL = 10'h0f8;
  localparam logic [9:0] IDX_IRQ_STATUS = 10'h0f9;
  localparam logic [9:0] IDX_IRQ_MASK = 10'h0fa;
  localparam int MODE_TYPE_BIT = 4;
  localparam int WHS_DIR_BIT = 7;
  localparam int CTRL_CFG_BIT = 0;
  localparam int IRQ_WRITE_DONE = 0;
  localparam int IRQ_READ_VALID = 1;
  localparam int IRQ_LOCK_DENY = 2;
  localparam int IRQ_W = 3;
  localparam logic [1:0] WSTAT_READY = 2'b11;
  localparam logic [1:0] WSTAT_LOW_HELD = 2'b10;
  localparam logic [1:0] WSTAT_BUSY = 2'b00;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam logic [2:0] OP_READ = 3'b110;
  localparam logic [2:0] OP_WRITE = 3'b101;
  localparam logic [2:0] OP_EWEN = 3'b100;
  localparam logic [1:0] EWEN_FIELD = 2'b11;
  localparam int LOCKED_WORDS = 64;
  localparam int CLK_PERIOD_NS = 100;
  localparam int SK_HALF_NS = 500;
  localparam int CS_GAP_NS = 250;
  localparam int SK_HALF_CYC = (SK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CS_GAP_CYC = (CS_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : seap_pkg

// >>> test/seap_eeprom_model.sv
// Purpose: Behavioural 16-bit serial memory at the far end of the link.
// Assumes: Start bit, two opcode bits, address, data, all MSB first.
// Notes: Busy time short; a released data line shows the inverse level.
module seap_eeprom_model #(
  parameter int ABITS = 6,
  parameter int BUSY_NS = 20000
) (
  input wire logic cs,
  input wire logic sk,
  input wire logic di,
  output logic do_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem [256];
  logic [26:0] sh;
  logic [15:0] q;
  logic busy = 1'b0, wen = 1'b0, wpend = 1'b0, rdop = 1'b0;
  int n = 0;
  initial do_pin = 1'b0;
  always @(posedge cs) begin
    n = 0;
    rdop = 1'b0;
    do_pin = !busy;
  end
  always @(negedge busy) if (cs) do_pin = 1'b1;
  always @(negedge cs) begin
    do_pin = !do_pin;
    if (wpend) begin
      wpend = 1'b0;
      busy = 1'b1;
      #BUSY_NS busy = 1'b0;
    end
  end
  always @(posedge sk) if (cs && (n > 0 || di)) begin
    if (rdop) begin
      do_pin = q[15];
      q = q << 1;
    end else begin
      sh = {sh[25:0], di};
      n++;
      if (n == 3 + ABITS) begin
        q = mem[sh[ABITS-1:0]];
        rdop = sh[ABITS+1:ABITS] == 2'b10;
        if (sh[ABITS+1:ABITS] == 2'b00) wen = sh[ABITS-1:ABITS-2] == 2'b11;
      end
      if (n == 19 + ABITS && wen && sh[ABITS+17:ABITS+16] == 2'b01) begin
        mem[sh[ABITS+15:16]] = sh[15:0];
        wpend = 1'b1;
      end
    end
  end
endmodule : seap_eeprom_model

// >>> test/seap_properties.sv
// Purpose: Port assertions for seap_top.
// Assumes: One aclk domain, synchronous reset.
// Notes: Bound to every seap_top.
module seap_properties (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic eeprom_serial_out_pin,
  input wire logic eeprom_serial_clock_pin,
  input wire logic eeprom_chip_enable_pin
);
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence sk_high;
    eeprom_serial_clock_pin [*5] ##1 !eeprom_serial_clock_pin;
  endsequence
  sequence sk_low;
    (!eeprom_serial_clock_pin) [*5];
  endsequence
  a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write response late");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
    else $error("read response late");
  a_aw_ready_drop: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("write address ready stayed high");
  a_sk_high_half: assert property ($rose(eeprom_serial_clock_pin) |-> sk_high)
    else $error("serial clock high phase wrong");
  a_sk_low_half: assert property ($fell(eeprom_serial_clock_pin) |-> sk_low)
    else $error("serial clock low phase short");
  a_sk_in_frame: assert property (eeprom_serial_clock_pin |-> eeprom_chip_enable_pin)
    else $error("serial clock outside frame");
  a_dout_steady: assert property (eeprom_serial_clock_pin && $past(eeprom_serial_clock_pin)
    |-> $stable(eeprom_serial_out_pin)) else $error("data moved while clock high");
endmodule : seap_properties
bind seap_top seap_properties u_props (.*);

// >>> test/test_serial_eeprom_access_port.sv
// Purpose: Self-checking bench for seap_top.
// Assumes: Task argument r selects register index 0xf0 plus r.
// Notes: Memory busy time kept short to save run time.
module test_serial_eeprom_access_port;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic eeprom_serial_in_pin, eeprom_serial_out_pin, eeprom_serial_clock_pin;
  logic eeprom_chip_enable_pin;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, v;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  int fail_count = 0, cmp_count = 0;
  always #50 aclk = ~aclk;
  seap_top DUT (.*);
  seap_eeprom_model u_mem (.cs(eeprom_chip_enable_pin), .sk(eeprom_serial_clock_pin),
    .di(eeprom_serial_out_pin), .do_pin(eeprom_serial_in_pin));
  task automatic give_verdict;
    if (fail_count == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [31:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== {24'h00_0000, exp}) begin
      fail_count++;
      $display("ERROR at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic hang;
    fail_count++;
    give_verdict();
  endtask : hang
  task automatic wr(input logic [3:0] r, input logic [7:0] d);
    int i;
    @(posedge aclk);
    s_axi_awaddr <= {6'h0f, r, 2'b00};
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    if (i == 50) hang();
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] r);
    int i;
    @(posedge aclk);
    s_axi_araddr <= {6'h0f, r, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    if (i == 50) hang();
    v = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
  // Bounded poll: a stuck handshake bit ends the run
  task automatic poll(input logic [3:0] r, input logic [7:0] m);
    int i;
    rd(r);
    for (i = 0; i < 400 && (v[7:0] & m) !== m; i++) rd(r);
    if ((v[7:0] & m) !== m) hang();
  endtask : poll
  task automatic t_gate;
    wr(4'h2, 8'h07);
    rd(4'h2);
    chk(v, 8'h00);
    rd(4'hf);
    chk(resp, 8'h02);
    wr(4'h8, 8'h01);
    chk(resp, 8'h00);
    rd(4'h2);
    chk(v, 8'h00);
    rd(4'h4);
    chk(v, 8'h03);
  endtask : t_gate
  task automatic t_write;
    wr(4'h4, 8'h80);
    rd(4'h4);
    chk(v, 8'h83);
    wr(4'h2, 8'h05);
    poll(4'h4, 8'h03);
    wr(4'h3, 8'h5a);
    rd(4'h4);
    chk(v, 8'h82);
    wr(4'h3, 8'ha5);
    rd(4'h4);
    chk(v, 8'h80);
    poll(4'h4, 8'h03);
    rd(4'h2);
    chk(v, 8'h06);
  endtask : t_write
  task automatic t_read;
    wr(4'h4, 8'h00);
    wr(4'h2, 8'h05);
    rd(4'h6);
    chk(v, 8'h00);
    rd(4'h5);
    rd(4'h2);
    chk(v, 8'h05);
    poll(4'h6, 8'h01);
    rd(4'h5);
    chk(v, 8'h5a);
    rd(4'h5);
    chk(v, 8'ha5);
    rd(4'h6);
    chk(v, 8'h00);
    rd(4'h2);
    chk(v, 8'h06);
  endtask : t_read
  task automatic t_lock;
    wr(4'h1, 8'h01);
    wr(4'h1, 8'h00);
    rd(4'h1);
    chk(v, 8'h01);
    rd(4'h9);
    wr(4'ha, 8'h04);
    wr(4'h2, 8'h02);
    poll(4'h6, 8'h01);
    rd(4'h5);
    chk(v, 8'h00);
    chk(irq, 8'h01);
    rd(4'h9);
    chk(v, 8'h06);
    repeat (2) @(posedge aclk);
    chk(irq, 8'h00);
    // Denied word write still completes the pair and steps the pointer
    wr(4'h4, 8'h80);
    wr(4'h3, 8'h11);
    wr(4'h3, 8'h22);
    poll(4'h4, 8'h03);
    rd(4'h2);
    chk(v, 8'h03);
  endtask : t_lock
  task automatic t_reset;
    aresetn <= 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    wr(4'h8, 8'h01);
    rd(4'h1);
    chk(v, 8'h00);
    wr(4'h1, 8'h10);
    rd(4'h1);
    chk(v, 8'h10);
  endtask : t_reset
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    t_gate();
    t_write();
    t_read();
    t_lock();
    t_reset();
    give_verdict();
  end
endmodule : test_serial_eeprom_access_port
